/* hw/toc_pkg.sv */
// constants and field layouts for the timer compare and one pulse block
// Contract
// - compare match sets its flag, drives its pin to level, may raise irq
// - compare pin latches read low throughout reset
// - flag clears after status read with flag set, then compare low access
// - high byte write blocks matches until the low byte is written
// - disabled pin ignores level bit; the match still flags and interrupts
// - divide by two acts at equality, slower clocks at compare plus one
// - timer tick is core clock over two, four or eight, or external
// - force bit copies level to enabled pin without flag or interrupt
// - force bits do nothing in one pulse or pwm mode
// - one pulse trigger reloads counter, drives level two, flags, loads capture
// - one pulse mode: compare one match drives level one, ending pulse
// - one pulse trigger flag requests irq when capture irq enabled
// - one pulse mode never sets compare flag one; flag two still works
// - pwm and one pulse both selected means pwm only
// - equal levels in one pulse mode give a constant pin
// - one pulse mode: capture one disabled, capture two still works
// - one pulse mode: compare two flags only, drives no pin
// - pwm owns compare channel one and compare register two
// - compare pins work while capture channels are also in use
// - compare registers reset to 8000h, changed only by software writes
// - compare registers checked against the counter every timer tick
package toc_pkg;
   localparam logic [7:0] OFS_CTRL1 = 8'h00;
   localparam logic [7:0] OFS_CTRL2 = 8'h04;
   localparam logic [7:0] OFS_STATUS = 8'h08;
   localparam logic [7:0] OFS_CMP1_HI = 8'h0C;
   localparam logic [7:0] OFS_CMP1_LO = 8'h10;
   localparam logic [7:0] OFS_CMP2_HI = 8'h14;
   localparam logic [7:0] OFS_CMP2_LO = 8'h18;
   localparam logic [7:0] OFS_CAP1_HI = 8'h1C;
   localparam logic [7:0] OFS_CAP1_LO = 8'h20;
   localparam logic [7:0] OFS_CAP2_HI = 8'h24;
   localparam logic [7:0] OFS_CAP2_LO = 8'h28;
   localparam logic [7:0] OFS_CNT_HI = 8'h2C;
   localparam logic [7:0] OFS_CNT_LO = 8'h30;

   // status bit positions
   localparam int ST_CMP1 = 0;
   localparam int ST_CMP2 = 1;
   localparam int ST_CAP1 = 2;
   localparam int ST_CAP2 = 3;
   // force bits in a control one write
   localparam int C1_FORCE1 = 3;
   localparam int C1_FORCE2 = 4;

   localparam logic [15:0] CMP_RESET = 16'h8000;
   localparam logic [15:0] CNT_RELOAD = 16'hFFFC;
   localparam logic [15:0] CAP_PULSE_LOAD = 16'hFFFD;
   localparam logic [7:0] CTRL1_RESET = 8'h00;
   localparam logic [7:0] CTRL2_RESET = 8'h00;

   // clock select codes
   localparam logic [1:0] CLK_DIV4 = 2'b00;
   localparam logic [1:0] CLK_DIV2 = 2'b01;
   localparam logic [1:0] CLK_DIV8 = 2'b10;
   localparam logic [1:0] CLK_EXT = 2'b11;

   // control one: bit 7..0
   typedef struct packed {
      logic capture_irq_enable;
      logic compare_irq_enable;
      logic spare;
      logic force2;
      logic force1;
      logic level_during_pulse;
      logic capture_edge_select_one;
      logic level_after_pulse;
   } toc_ctrl1_t;

   // control two: bit 7..0
   typedef struct packed {
      logic pin_enable_one;
      logic pin_enable_two;
      logic single_pulse_select;
      logic pwm_select;
      logic [1:0] timer_clock_select;
      logic ext_edge_select;
      logic capture_edge_select_two;
   } toc_ctrl2_t;
endpackage : toc_pkg

/* hw/toc_sync.sv */
// two flip-flop synchroniser for pin inputs
`default_nettype none
module toc_sync #(
   parameter int W = 3
) (
   input wire logic CORE_CLK,
   input wire logic RST_N,
   input wire logic [W-1:0] D,
   output logic [W-1:0] Q
);
   logic [W-1:0] meta;

   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         meta <= '0;
         Q <= '0;
      end else begin
         meta <= D;
         Q <= meta;
      end
   end
endmodule : toc_sync
`default_nettype wire

/* hw/toc_timer.sv */
// compare, force and one pulse logic of a 16-bit timer with apb registers
`default_nettype none
module toc_timer (
   input wire logic CORE_CLK,
   input wire logic RST_N,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   input wire logic CPU_IRQ_MASK,
   input wire logic CAPTURE_INPUT_ONE,
   input wire logic CAPTURE_INPUT_TWO,
   input wire logic EXT_TIMER_CLK,
   output logic [1:0] COMPARE_OUTPUT_PIN,
   output logic [1:0] COMPARE_OUTPUT_OE,
   output logic TIMER_IRQ
);
   import toc_pkg::*;

   toc_pkg::toc_ctrl1_t ctrl1;
   toc_pkg::toc_ctrl2_t ctrl2;
   logic [15:0] compare_value [2];
   logic [1:0] compare_inhibit;
   logic [15:0] capture_value_one;
   logic [15:0] capture_value_two;
   logic [15:0] count;
   logic [2:0] presc;
   logic [2:0] pins_sync;
   logic [2:0] pins_last;
   logic tick;
   logic count_new;
   logic [1:0] hit;
   logic [1:0] pend;
   logic [1:0] match_event;
   logic [3:0] flags;
   logic [3:0] armed;
   logic [3:0] flag_set;
   logic [3:0] flag_clr;
   logic pwm_mode;
   logic pulse_mode;
   logic cap1_edge;
   logic cap2_edge;
   logic ext_edge;
   logic pulse_trigger;
   logic access;
   logic wr;
   logic rd;
   logic [7:0] next_rdata;
   logic next_err;

   // pins cross into the core clock before anything looks at them
   toc_sync #(
      .W(3)
   ) u_sync (
      .CORE_CLK(CORE_CLK),
      .RST_N(RST_N),
      .D({EXT_TIMER_CLK, CAPTURE_INPUT_TWO, CAPTURE_INPUT_ONE}),
      .Q(pins_sync)
   );

   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         pins_last <= '0;
      end else begin
         pins_last <= pins_sync;
      end
   end

   // edge select bit high picks the rising edge
   always_comb begin
      cap1_edge = ctrl1.capture_edge_select_one ?
                  (pins_sync[0] & ~pins_last[0]) :
                  (~pins_sync[0] & pins_last[0]);
      cap2_edge = ctrl2.capture_edge_select_two ?
                  (pins_sync[1] & ~pins_last[1]) :
                  (~pins_sync[1] & pins_last[1]);
      ext_edge = ctrl2.ext_edge_select ?
                 (pins_sync[2] & ~pins_last[2]) :
                 (~pins_sync[2] & pins_last[2]);
   end

   // pwm wins when both mode bits are set
   assign pwm_mode = ctrl2.pwm_select;
   assign pulse_mode = ctrl2.single_pulse_select & ~ctrl2.pwm_select;
   assign pulse_trigger = pulse_mode & cap1_edge;

   assign access = PSEL & PENABLE & PREADY;
   assign wr = access & PWRITE;
   assign rd = access & ~PWRITE;

   // prescaler and tick
   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         presc <= '0;
      end else begin
         presc <= presc + 3'd1;
      end
   end

   always_comb begin
      case (ctrl2.timer_clock_select)
         CLK_DIV2: tick = presc[0];
         CLK_DIV4: tick = &presc[1:0];
         CLK_DIV8: tick = &presc;
         CLK_EXT: tick = ext_edge;
         default: tick = 1'b0;
      endcase
   end

   // free running counter; reload on a pulse trigger or pwm period end
   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         count <= CNT_RELOAD;
      end else if (pulse_trigger) begin
         count <= CNT_RELOAD;
      end else if (pwm_mode && match_event[1]) begin
         count <= CNT_RELOAD;
      end else if (tick) begin
         count <= count + 16'h0001;
      end
   end

   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         count_new <= 1'b0;
      end else begin
         count_new <= tick;
      end
   end

   // one compare per counter value; slower clocks act one count late
   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++) begin : g_cmp
         assign hit[gi] = count_new & ~compare_inhibit[gi] &
                          (count == compare_value[gi]);
         assign match_event[gi] =
            (ctrl2.timer_clock_select == CLK_DIV2) ?
            hit[gi] : (pend[gi] & tick);

         always_ff @(posedge CORE_CLK or negedge RST_N) begin
            if (!RST_N) begin
               pend[gi] <= 1'b0;
            end else if (ctrl2.timer_clock_select == CLK_DIV2) begin
               pend[gi] <= 1'b0;
            end else if (hit[gi]) begin
               pend[gi] <= 1'b1;
            end else if (tick) begin
               pend[gi] <= 1'b0;
            end
         end
      end
   endgenerate

   // control registers
   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         ctrl1 <= CTRL1_RESET;
         ctrl2 <= CTRL2_RESET;
      end else if (wr && PADDR == OFS_CTRL1) begin
         // force bits are write strobes and never stored
         ctrl1 <= PWDATA[7:0] & ~(8'h18);
      end else if (wr && PADDR == OFS_CTRL2) begin
         ctrl2 <= PWDATA[7:0];
      end
   end

   // compare registers change only on software writes
   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         compare_value[0] <= CMP_RESET;
         compare_value[1] <= CMP_RESET;
         compare_inhibit <= '0;
      end else if (wr) begin
         case (PADDR)
            OFS_CMP1_HI: begin
               compare_value[0][15:8] <= PWDATA[7:0];
               compare_inhibit[0] <= 1'b1;
            end
            OFS_CMP1_LO: begin
               compare_value[0][7:0] <= PWDATA[7:0];
               compare_inhibit[0] <= 1'b0;
            end
            OFS_CMP2_HI: begin
               compare_value[1][15:8] <= PWDATA[7:0];
               compare_inhibit[1] <= 1'b1;
            end
            OFS_CMP2_LO: begin
               compare_value[1][7:0] <= PWDATA[7:0];
               compare_inhibit[1] <= 1'b0;
            end
            default: begin
               compare_inhibit <= compare_inhibit;
            end
         endcase
      end
   end

   // capture registers; capture one belongs to the pulse in one pulse mode
   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         capture_value_one <= '0;
      end else if (pulse_trigger) begin
         capture_value_one <= CAP_PULSE_LOAD;
      end else if (cap1_edge && !pulse_mode && !pwm_mode) begin
         capture_value_one <= count;
      end
   end

   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         capture_value_two <= '0;
      end else if (cap2_edge) begin
         capture_value_two <= count;
      end
   end

   // flag sources
   always_comb begin
      flag_set = '0;
      flag_set[ST_CMP1] = match_event[0] & ~pwm_mode & ~pulse_mode;
      flag_set[ST_CMP2] = match_event[1] & ~pwm_mode;
      flag_set[ST_CAP1] = pulse_trigger |
                          (cap1_edge & ~pulse_mode & ~pwm_mode) |
                          (pwm_mode & match_event[1]);
      flag_set[ST_CAP2] = cap2_edge;
   end

   // second step of the clear: any access to the matching low byte
   always_comb begin
      flag_clr = '0;
      flag_clr[ST_CMP1] = access & armed[ST_CMP1] &
                          (PADDR == OFS_CMP1_LO);
      flag_clr[ST_CMP2] = access & armed[ST_CMP2] &
                          (PADDR == OFS_CMP2_LO);
      flag_clr[ST_CAP1] = access & armed[ST_CAP1] &
                          (PADDR == OFS_CAP1_LO);
      flag_clr[ST_CAP2] = access & armed[ST_CAP2] &
                          (PADDR == OFS_CAP2_LO);
   end

   // a new event in the clearing cycle survives
   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         flags <= '0;
      end else begin
         flags <= flag_set | (flags & ~flag_clr);
      end
   end

   // first step of the clear: status read while the flag is set
   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         armed <= '0;
      end else if (rd && PADDR == OFS_STATUS) begin
         armed <= (armed & ~flag_clr) | flags;
      end else begin
         armed <= armed & ~flag_clr;
      end
   end

   // pin one latch: normal compare, pulse, pwm, force
   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         COMPARE_OUTPUT_PIN[0] <= 1'b0;
      end else if (!ctrl2.pin_enable_one) begin
         COMPARE_OUTPUT_PIN[0] <= COMPARE_OUTPUT_PIN[0];
      end else if (pulse_trigger) begin
         COMPARE_OUTPUT_PIN[0] <= ctrl1.level_during_pulse;
      end else if (pulse_mode) begin
         if (match_event[0]) begin
            COMPARE_OUTPUT_PIN[0] <= ctrl1.level_after_pulse;
         end
      end else if (pwm_mode) begin
         if (match_event[1]) begin
            COMPARE_OUTPUT_PIN[0] <= ctrl1.level_during_pulse;
         end else if (match_event[0]) begin
            COMPARE_OUTPUT_PIN[0] <= ctrl1.level_after_pulse;
         end
      end else if (wr && PADDR == OFS_CTRL1 && PWDATA[C1_FORCE1]) begin
         COMPARE_OUTPUT_PIN[0] <= PWDATA[0];
      end else if (match_event[0]) begin
         COMPARE_OUTPUT_PIN[0] <= ctrl1.level_after_pulse;
      end
   end

   // pin two latch; level two is taken by the pulse in the special modes
   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         COMPARE_OUTPUT_PIN[1] <= 1'b0;
      end else if (!ctrl2.pin_enable_two || pulse_mode || pwm_mode) begin
         COMPARE_OUTPUT_PIN[1] <= COMPARE_OUTPUT_PIN[1];
      end else if (wr && PADDR == OFS_CTRL1 && PWDATA[C1_FORCE2]) begin
         COMPARE_OUTPUT_PIN[1] <= PWDATA[2];
      end else if (match_event[1]) begin
         COMPARE_OUTPUT_PIN[1] <= ctrl1.level_during_pulse;
      end
   end

   // a disabled compare pin is released to general i/o
   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         COMPARE_OUTPUT_OE <= '0;
      end else begin
         COMPARE_OUTPUT_OE <= {ctrl2.pin_enable_two,
                               ctrl2.pin_enable_one};
      end
   end

   // one shared request line, held while any enabled flag is pending and CPU_IRQ_MASK is low
   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         TIMER_IRQ <= 1'b0;
      end else begin
         TIMER_IRQ <= ~CPU_IRQ_MASK &
            ((ctrl1.compare_irq_enable &
              (flags[ST_CMP1] | flags[ST_CMP2])) |
             (ctrl1.capture_irq_enable &
              (flags[ST_CAP1] | flags[ST_CAP2])));
      end
   end

   // read mux, sampled in the setup cycle so data is ready in access
   always_comb begin
      next_err = 1'b0;
      case (PADDR)
         OFS_CTRL1: next_rdata = ctrl1;
         OFS_CTRL2: next_rdata = ctrl2;
         OFS_STATUS: next_rdata = {4'h0, flags};
         OFS_CMP1_HI: next_rdata = compare_value[0][15:8];
         OFS_CMP1_LO: next_rdata = compare_value[0][7:0];
         OFS_CMP2_HI: next_rdata = compare_value[1][15:8];
         OFS_CMP2_LO: next_rdata = compare_value[1][7:0];
         OFS_CAP1_HI: next_rdata = capture_value_one[15:8];
         OFS_CAP1_LO: next_rdata = capture_value_one[7:0];
         OFS_CAP2_HI: next_rdata = capture_value_two[15:8];
         OFS_CAP2_LO: next_rdata = capture_value_two[7:0];
         OFS_CNT_HI: next_rdata = count[15:8];
         OFS_CNT_LO: next_rdata = count[7:0];
         default: begin
            next_rdata = 8'h00;
            next_err = 1'b1;
         end
      endcase
   end

   // one wait-free access phase; unmapped addresses answer with an error
   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         PREADY <= 1'b0;
         PSLVERR <= 1'b0;
         PRDATA <= '0;
      end else begin
         PREADY <= PSEL & ~PENABLE;
         PSLVERR <= PSEL & ~PENABLE & next_err;
         if (PSEL && !PENABLE && !PWRITE) begin
            PRDATA <= {24'h00_0000, next_rdata};
         end
      end
   end
endmodule : toc_timer
`default_nettype wire

/* verification/timer_output_compare_one_pulse_tb_top.sv */
// self-checking bench for the timer compare and one pulse block
`default_nettype none
module timer_output_compare_one_pulse_tb_top import toc_pkg::*;;
   timeunit 1ns;
   timeprecision 1ns;
   logic core_clk = 1'b0, rst_n = 1'b1, psel = 1'b0, penable = 1'b0;
   logic pwrite = 1'b0, irq_mask = 1'b0, ext_run = 1'b0;
   logic [1:0] trig = 2'b00;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000, prdata, rdv;
   logic pready, pslverr, errv, irq, cap_one, cap_two, ext_clk;
   logic [1:0] pin, oe;
   logic [1:0] sels [4] = '{CLK_DIV2, CLK_DIV4, CLK_DIV8, CLK_EXT};
   int failures = 0, cmp_count = 0, cycles = 0;

   toc_timer u_dut (.CORE_CLK(core_clk), .RST_N(rst_n), .PSEL(psel),
      .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
      .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
      .CPU_IRQ_MASK(irq_mask), .CAPTURE_INPUT_ONE(cap_one),
      .CAPTURE_INPUT_TWO(cap_two), .EXT_TIMER_CLK(ext_clk),
      .COMPARE_OUTPUT_PIN(pin), .COMPARE_OUTPUT_OE(oe), .TIMER_IRQ(irq));
   toc_pin_model u_pins (.clk(core_clk), .rst_n(rst_n), .trig(trig),
      .ext_run(ext_run), .cap_one(cap_one), .cap_two(cap_two),
      .ext_clk(ext_clk));

   always #10 core_clk = ~core_clk;

   task automatic report_and_stop();
      $display("comparisons %0d failures %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : report_and_stop

   // the whole run needs well under this many cycles
   always @(posedge core_clk) begin
      cycles <= cycles + 1;
      if (cycles == 30000) begin
         failures++;
         $display("unexpected at %0t: run hung", $time);
         report_and_stop();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         failures++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask : chk

   task automatic apb(input logic wr, input logic [7:0] a,
         input logic [7:0] d);
      @(posedge core_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= 32'(d);
      @(posedge core_clk);
      penable <= 1'b1;
      @(posedge core_clk);
      while (pready !== 1'b1) @(posedge core_clk);
      rdv = prdata;
      errv = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic chk_rd(input logic [7:0] a, input logic [7:0] e);
      apb(1'b0, a, 8'h00);
      chk(rdv, 32'(e));
   endtask : chk_rd

   // w selects pin bit 0, pin bit 1 or the interrupt line (2)
   task automatic wait_sig(input int w, input logic v, output int n);
      n = 0;
      while ((w == 2 ? irq : pin[w[0]]) !== v && n < 3000) begin
         @(posedge core_clk);
         n++;
      end
      chk(32'(n < 3000), 32'h0000_0001);
   endtask : wait_sig

   task automatic do_reset();
      rst_n <= 1'b0;
      repeat (5) @(posedge core_clk);
      rst_n <= 1'b1;
   endtask : do_reset

   initial begin
      int k, n, ch;
      logic [15:0] c;
      logic lv;
      logic [7:0] hi_a;
      void'($urandom(32'h639c_7ab5));
      do_reset();
      for (k = 0; k < 4; k++) begin
         chk_rd(OFS_CMP1_HI + 8'(4 * k), k[0] ? 8'h00 : 8'h80);
      end
      chk_rd(OFS_STATUS, 8'h00);
      apb(1'b1, 8'h3C, 8'hFF);
      chk(32'(errv), 32'h0000_0001);
      apb(1'b0, 8'h40, 8'h00);
      chk(rdv, 32'h0000_0000);
      chk(32'(errv), 32'h0000_0001);
      // one match per clock source, channels alternating
      for (k = 0; k < 4; k++) begin
         do_reset();
         ch = k % 2;
         hi_a = ch ? OFS_CMP2_HI : OFS_CMP1_HI;
         c = 16'h0030 + 16'($urandom_range(15));
         lv = 1'($urandom_range(1));
         ext_run <= (sels[k] == CLK_EXT);
         apb(1'b1, OFS_CTRL1, 8'h40 | (8'(lv) << (2 * ch)));
         apb(1'b1, OFS_CTRL2, {2'b11, 2'b00, sels[k], 2'b00});
         apb(1'b1, hi_a, c[15:8]);
         repeat (40) @(posedge core_clk);
         chk_rd(OFS_STATUS, 8'h00);
         apb(1'b1, hi_a + 8'h04, c[7:0]);
         // a capture two event while the compare runs; its irq stays off
         trig <= 2'b10;
         @(posedge core_clk);
         trig <= 2'b00;
         wait_sig(2, 1'b1, n);
         if (sels[k] == CLK_DIV8 || sels[k] == CLK_EXT) begin
            chk_rd(OFS_CNT_LO, c[7:0] + 8'h01);
         end
         chk(32'(pin[ch]), 32'(lv));
         apb(1'b1, hi_a + 8'h04, c[7:0]);
         chk_rd(OFS_STATUS, (8'h01 << ch) | 8'h08);
         irq_mask <= 1'b1;
         repeat (3) @(posedge core_clk);
         chk(32'(irq), 32'h0000_0000);
         irq_mask <= 1'b0;
         repeat (3) @(posedge core_clk);
         chk(32'(irq), 32'h0000_0001);
         apb(1'b1, hi_a + 8'h04, c[7:0]);
         repeat (2) @(posedge core_clk);
         chk(32'(irq), 32'h0000_0000);
         chk_rd(OFS_STATUS, 8'h08);
      end
      ext_run <= 1'b0;
      do_reset();
      // pins still released: forcing must leave both latches alone
      apb(1'b1, OFS_CTRL1, 8'h5D);
      repeat (2) @(posedge core_clk);
      chk(32'(pin), 32'h0000_0000);
      chk(32'(oe), 32'h0000_0000);
      apb(1'b1, OFS_CTRL2, 8'hC0);
      repeat (2) @(posedge core_clk);
      chk(32'(oe), 32'h0000_0003);
      apb(1'b1, OFS_CTRL1, 8'h54);
      apb(1'b1, OFS_CTRL1, 8'h49);
      repeat (2) @(posedge core_clk);
      chk(32'(pin), 32'h0000_0003);
      chk(32'(irq), 32'h0000_0000);
      chk_rd(OFS_STATUS, 8'h00);
      apb(1'b1, OFS_CTRL2, 8'hE0);
      apb(1'b1, OFS_CTRL1, 8'h48);
      repeat (2) @(posedge core_clk);
      chk(32'(pin[0]), 32'h0000_0001);
      // both mode bits set: only pwm runs, so a capture one edge does nothing
      apb(1'b1, OFS_CTRL2, 8'hF0);
      trig <= 2'b01;
      @(posedge core_clk);
      trig <= 2'b00;
      repeat (20) @(posedge core_clk);
      chk(32'(pin[0]), 32'h0000_0001);
      chk_rd(OFS_STATUS, 8'h00);
      chk_rd(OFS_CAP1_LO, 8'h00);
      // single pulse: compare one sets the length, compare two elapsed time
      do_reset();
      apb(1'b1, OFS_CMP1_HI, 8'h00);
      apb(1'b1, OFS_CMP1_LO, 8'h20);
      apb(1'b1, OFS_CMP2_HI, 8'h00);
      apb(1'b1, OFS_CMP2_LO, 8'h10);
      apb(1'b1, OFS_CTRL1, 8'hC6);
      apb(1'b1, OFS_CTRL2, 8'hE7);
      trig <= 2'b11;
      @(posedge core_clk);
      trig <= 2'b00;
      wait_sig(0, 1'b1, n);
      wait_sig(0, 1'b0, n);
      // length in core cycles is (compare + 4) times the prescaler of two
      chk(32'(n >= 70 && n <= 76), 32'h0000_0001);
      chk_rd(OFS_CAP1_HI, CAP_PULSE_LOAD[15:8]);
      chk_rd(OFS_CAP1_LO, CAP_PULSE_LOAD[7:0]);
      chk(32'(irq), 32'h0000_0001);
      chk_rd(OFS_STATUS, 8'h0E);
      chk(32'(pin[1]), 32'h0000_0000);
      apb(1'b1, OFS_CTRL1, 8'hC7);
      trig <= 2'b01;
      @(posedge core_clk);
      trig <= 2'b00;
      repeat (100) @(posedge core_clk);
      chk(32'(pin[0]), 32'h0000_0001);
      report_and_stop();
   end
endmodule : timer_output_compare_one_pulse_tb_top

bind toc_timer toc_timer_assertions u_chk (.CORE_CLK(CORE_CLK),
   .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE), .PADDR(PADDR),
   .PREADY(PREADY), .PSLVERR(PSLVERR), .CPU_IRQ_MASK(CPU_IRQ_MASK),
   .COMPARE_OUTPUT_PIN(COMPARE_OUTPUT_PIN),
   .COMPARE_OUTPUT_OE(COMPARE_OUTPUT_OE), .TIMER_IRQ(TIMER_IRQ));
`default_nettype wire

/* verification/toc_pin_model.sv */
// pin side model: capture input pulses and an external timer clock
`default_nettype none
module toc_pin_model (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [1:0] trig,
   input wire logic ext_run,
   output logic cap_one,
   output logic cap_two,
   output logic ext_clk
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [3:0] hold_one, hold_two;
   logic [2:0] div;
   // eight cycles high outlasts the two flop synchroniser
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         hold_one <= 4'h0;
         hold_two <= 4'h0;
      end else begin
         hold_one <= trig[0] ? 4'h8 : hold_one - 4'(hold_one != 4'h0);
         hold_two <= trig[1] ? 4'h8 : hold_two - 4'(hold_two != 4'h0);
      end
   end
   // one active edge per eight core cycles; stands still when not running
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         div <= 3'h0;
      end else if (ext_run) begin
         div <= div + 3'h1;
      end
   end
   assign cap_one = hold_one != 4'h0;
   assign cap_two = hold_two != 4'h0;
   assign ext_clk = div[2];
endmodule : toc_pin_model
`default_nettype wire

/* verification/toc_timer_assertions.sv */
// port-level checks for the timer compare and one pulse block
`default_nettype none
module toc_timer_assertions import toc_pkg::*; (
   input wire logic CORE_CLK,
   input wire logic RST_N,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic [7:0] PADDR,
   input wire logic PREADY,
   input wire logic PSLVERR,
   input wire logic CPU_IRQ_MASK,
   input wire logic [1:0] COMPARE_OUTPUT_PIN,
   input wire logic [1:0] COMPARE_OUTPUT_OE,
   input wire logic TIMER_IRQ
);
   default clocking cb @(posedge CORE_CLK);
   endclocking
   sequence setup_s;
      PSEL && !PENABLE;
   endsequence
   sequence access_s;
      PSEL && PENABLE && PREADY;
   endsequence
   property ready_p;
      disable iff (!RST_N) setup_s |=> access_s;
   endproperty
   bus_ready_a: assert property (ready_p)
      else $error("no ready in the cycle after setup");
   ready_once_a: assert property (disable iff (!RST_N) PREADY |=> !PREADY)
      else $error("ready held over two cycles");
   err_ready_a: assert property (disable iff (!RST_N) PSLVERR |-> PREADY)
      else $error("error without ready");
   unmapped_err_a: assert property (disable iff (!RST_N)
      PSEL && PENABLE && PREADY && PADDR > OFS_CNT_LO |-> PSLVERR)
      else $error("unmapped access not refused");
   mapped_ok_a: assert property (disable iff (!RST_N)
      access_s ##0 (PADDR <= OFS_CNT_LO && PADDR[1:0] == 2'b00)
      |-> !PSLVERR)
      else $error("mapped access refused");
   reset_pins_a: assert property (
      !RST_N |-> COMPARE_OUTPUT_PIN == 2'b00 && !TIMER_IRQ)
      else $error("pin latch not low in reset");
   pin_hold_a: assert property (disable iff (!RST_N)
      !COMPARE_OUTPUT_OE[0] && !$past(COMPARE_OUTPUT_OE[0])
      |-> $stable(COMPARE_OUTPUT_PIN[0]))
      else $error("disabled pin changed");
   irq_mask_a: assert property (disable iff (!RST_N)
      CPU_IRQ_MASK && $past(CPU_IRQ_MASK) |-> !TIMER_IRQ)
      else $error("interrupt while masked");
endmodule : toc_timer_assertions
`default_nettype wire
